/* File: dram_train_cfg.svh */
// Purpose: Constants for the CA training, write leveling and ODT block
// Assumes: Mode-register address and operand layout of the CA bus
// Notes: Definitions only, no logic
`ifndef DRAM_TRAIN_CFG_SVH
`define DRAM_TRAIN_CFG_SVH

`define CA_WIDTH 10
`define DQ_WIDTH 32
`define SYNC_WIDTH 14

// Mode-register addresses (8 bit)
`define ADDR_TRAIN_ENTRY 8'h29
`define ADDR_TRAIN_EXIT 8'h2a
`define ADDR_TRAIN_REMAP 8'h30
`define ADDR_LAT_LEVEL 8'h02
`define ADDR_TERM_CFG 8'h0b

// Operands of the training writes
`define OP_TRAIN_ENTRY 8'ha4
`define OP_TRAIN_EXIT 8'ha8
`define OP_TRAIN_REMAP 8'hc0

// Field positions
`define LEVEL_BIT 7
`define TERM_PD_BIT 2
`define TERM_SEL_HI 1
`define TERM_SEL_LO 0
`define MRW_OPC_HI 3
`define MRW_OPC_LO 0
`define MRW_OPC 4'h0
`define MA_LO_HI 9
`define MA_LO_LO 4
`define MA_HI_HI 1
`define MA_HI_LO 0
`define OP_HI 9
`define OP_LO 2

// Second-session echo lanes and termination reset value
`define REMAP_CA_A 4
`define REMAP_CA_B 9
`define REMAP_DQ_A 0
`define REMAP_DQ_B 8
`define TERM_RESET 3'h0

// Sampler vector layout
`define SV_CK 0
`define SV_CS 1
`define SV_CKE 2
`define SV_DQS 3
`define SV_CA_LO 4
`define SV_CA_HI 13

`endif

/* File: dram_train_pkg.sv */
// Purpose: Types shared by the training block
// Assumes: dram_train_cfg.svh gives the widths
// Notes: Types only
`include "dram_train_cfg.svh"
package dram_train_pkg;
  typedef logic [`CA_WIDTH-1:0] ca_t;
  typedef logic [`DQ_WIDTH-1:0] dq_t;
  typedef enum logic [3:0]
  {
    ST_NORMAL = 4'h1,
    ST_TRAIN_A = 4'h2,
    ST_TRAIN_B = 4'h4,
    ST_LEVEL = 4'h8
  } mode_e;
endpackage

/* File: ddr_pin_sampler.sv */
// Purpose: Two-flop synchronisers and edge detection for the memory pins
// Assumes: Pins change slower than a few i_clock periods
// Notes: A third flop stage feeds the edge detectors only
`timescale 1ns/100ps
module ddr_pin_sampler
  import dram_train_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_ck,
  input wire logic i_cs_n,
  input wire logic i_cke,
  input wire logic i_dqs_t,
  input wire ca_t i_ca,
  output logic o_ck_rise,
  output logic o_ck_fall,
  output logic o_ck_level,
  output logic o_cs_n,
  output logic o_cke,
  output logic o_dqs_rise,
  output ca_t o_ca
);
  logic [`SYNC_WIDTH-1:0] meta_ff;
  logic [`SYNC_WIDTH-1:0] sync_ff;
  logic [`SYNC_WIDTH-1:0] prev_ff;
  logic [`SYNC_WIDTH-1:0] pins;

  assign pins = {i_ca, i_dqs_t, i_cke, i_cs_n, i_ck};

  // First stage is read by the second stage only
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end
    else if (i_clk_en)
    begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // CA and clock share one delay, so CA is taken in step with the edge
  assign o_ck_rise = i_clk_en & sync_ff[`SV_CK] & ~prev_ff[`SV_CK];
  assign o_ck_fall = i_clk_en & ~sync_ff[`SV_CK] & prev_ff[`SV_CK];
  assign o_dqs_rise = i_clk_en & sync_ff[`SV_DQS] & ~prev_ff[`SV_DQS];
  assign o_ck_level = sync_ff[`SV_CK];
  assign o_cs_n = sync_ff[`SV_CS];
  assign o_cke = sync_ff[`SV_CKE];
  assign o_ca = sync_ff[`SV_CA_HI:`SV_CA_LO];
endmodule

/* File: dram_ca_training_leveling_odt.sv */
// Purpose: CA training echo, write-leveling feedback and ODT switch control
// Assumes: Memory clock far slower than i_clock; read, power-down and
//   self-refresh status come from core logic on i_clock
// Notes: DQ pins are split into data and enable; strobes are never driven
//
// What this block does
// - Write 0x29 with 0xa4 enters CA training
// - Write 0x2a with 0xa8 leaves CA training
// - Entry and exit decode with equal edge values
// - Write 0x30 with 0xc0 at CKE high selects CA4/CA9 session
// - Session one: rising even DQ, falling odd DQ
// - Session two: CA4 on DQ0/1, CA9 DQ8/9
// - Unused DQ hold valid level; strobes stay static
// - Echo updates at falling edge after chip select
// - Irregular clock tolerated during phase shifting
// - Leveling bit of latency register controls leveling
// - Strobe rising edge samples clock onto all DQ
// - Termination pin acts directly, never clock-sampled
// - No termination in self refresh, deep power-down, reads
// - Power-down option decides pin control
// - Low two bits enable and select termination
// - CA training forces termination off
// - Write address and data taken from CA edges
`timescale 1ns/100ps
module dram_ca_training_leveling_odt
  import dram_train_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_ck,
  input wire logic i_cs_n,
  input wire logic i_cke,
  input wire ca_t i_ca,
  input wire logic i_dqs_t,
  input wire logic i_odt,
  input wire logic i_read_active,
  input wire logic i_power_down,
  input wire logic i_self_refresh,
  input wire logic i_deep_power_down,
  output dq_t o_dq,
  output dq_t o_dq_oe,
  output logic o_odt_dq,
  output logic o_odt_dqs,
  output logic [1:0] o_rtt_sel,
  output logic o_train_active,
  output logic o_level_active
);
  logic ck_rise;
  logic ck_fall;
  logic ck_level;
  logic cs_n_s;
  logic cke_s;
  logic dqs_rise;
  ca_t ca_s;

  mode_e mode_ff;
  mode_e nxt_mode;
  ca_t rise_ca_ff;
  logic cmd_pend_ff;
  logic [2:0] term_cfg_ff;
  dq_t dq_ff;
  dq_t dq_oe_ff;

  logic cmd_done;
  logic is_mrw;
  logic [7:0] mr_addr;
  logic [7:0] mr_op;
  logic hit_entry;
  logic hit_exit;
  logic hit_remap;
  logic hit_level;
  logic hit_term;
  dq_t cal_a;
  dq_t cal_b;
  dq_t cal_word;
  logic term_gate;

  // Session one skips CA4 and CA9, which move to session two
  function automatic int unsigned pair_ca(input int unsigned p);
    pair_ca = (p < 4) ? p : p + 1;
  endfunction

  // Address from falling CA1..0 over rising CA9..4; data on falling CA9..2
  function automatic logic mrw_match(input ca_t r, input ca_t f,
                                     input logic [7:0] a,
                                     input logic [7:0] op);
    mrw_match = (r[`MRW_OPC_HI:`MRW_OPC_LO] == `MRW_OPC) &&
                ({f[`MA_HI_HI:`MA_HI_LO], r[`MA_LO_HI:`MA_LO_LO]} == a) &&
                (f[`OP_HI:`OP_LO] == op);
  endfunction

  ddr_pin_sampler u_sampler
  (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_ck(i_ck),
    .i_cs_n(i_cs_n),
    .i_cke(i_cke),
    .i_dqs_t(i_dqs_t),
    .i_ca(i_ca),
    .o_ck_rise(ck_rise),
    .o_ck_fall(ck_fall),
    .o_ck_level(ck_level),
    .o_cs_n(cs_n_s),
    .o_cke(cke_s),
    .o_dqs_rise(dqs_rise),
    .o_ca(ca_s)
  );

  // Command framing: rising half latched when chip select is low, the
  // falling half completes it. Edges are found by sampling, so any clock
  // period or pulse width above a few i_clock periods is handled.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rise_ca_ff <= '0;
      cmd_pend_ff <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (ck_rise)
      begin
        cmd_pend_ff <= ~cs_n_s;
        if (!cs_n_s)
        begin
          rise_ca_ff <= ca_s;
        end
      end
      else if (ck_fall)
      begin
        cmd_pend_ff <= 1'b0;
      end
    end
  end

  assign cmd_done = ck_fall & cmd_pend_ff;
  assign is_mrw = (rise_ca_ff[`MRW_OPC_HI:`MRW_OPC_LO] == `MRW_OPC);
  assign mr_addr = {ca_s[`MA_HI_HI:`MA_HI_LO],
                    rise_ca_ff[`MA_LO_HI:`MA_LO_LO]};
  assign mr_op = ca_s[`OP_HI:`OP_LO];

  // Entry/exit patterns repeat on both edges, so they decode before
  // any CA skew has been trained out
  assign hit_entry = mrw_match(rise_ca_ff, ca_s, `ADDR_TRAIN_ENTRY,
                               `OP_TRAIN_ENTRY);
  assign hit_exit = mrw_match(rise_ca_ff, ca_s, `ADDR_TRAIN_EXIT,
                              `OP_TRAIN_EXIT);
  assign hit_remap = mrw_match(rise_ca_ff, ca_s, `ADDR_TRAIN_REMAP,
                               `OP_TRAIN_REMAP);
  assign hit_level = is_mrw && (mr_addr == `ADDR_LAT_LEVEL);
  assign hit_term = is_mrw && (mr_addr == `ADDR_TERM_CFG);

  always_comb
  begin
    nxt_mode = mode_ff;
    if (cmd_done)
    begin
      unique case (mode_ff)
        ST_NORMAL:
        begin
          if (hit_entry)
          begin
            nxt_mode = ST_TRAIN_A;
          end
          else if (hit_level && mr_op[`LEVEL_BIT])
          begin
            nxt_mode = ST_LEVEL;
          end
        end
        ST_TRAIN_A:
        begin
          if (hit_exit)
          begin
            nxt_mode = ST_NORMAL;
          end
          else if (hit_remap && cke_s)
          begin
            nxt_mode = ST_TRAIN_B;
          end
        end
        ST_TRAIN_B:
        begin
          if (hit_exit)
          begin
            nxt_mode = ST_NORMAL;
          end
        end
        ST_LEVEL:
        begin
          // Only the leveling-off write is honoured here
          if (hit_level && !mr_op[`LEVEL_BIT])
          begin
            nxt_mode = ST_NORMAL;
          end
        end
        default:
        begin
          nxt_mode = ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      mode_ff <= ST_NORMAL;
    end
    else if (i_clk_en)
    begin
      mode_ff <= nxt_mode;
    end
  end

  // Termination configuration is written only in normal decoding
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      term_cfg_ff <= `TERM_RESET;
    end
    else if (i_clk_en && cmd_done && mode_ff == ST_NORMAL && hit_term)
    begin
      term_cfg_ff <= mr_op[`TERM_PD_BIT:`TERM_SEL_LO];
    end
  end

  // Session one echo map; unused lanes stay at a valid low
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++)
    begin : g_map_a
      assign cal_a[2*gp] = rise_ca_ff[pair_ca(gp)];
      assign cal_a[2*gp+1] = ca_s[pair_ca(gp)];
    end
  endgenerate
  assign cal_a[`DQ_WIDTH-1:16] = '0;

  always_comb
  begin
    cal_b = '0;
    cal_b[`REMAP_DQ_A] = rise_ca_ff[`REMAP_CA_A];
    cal_b[`REMAP_DQ_A+1] = ca_s[`REMAP_CA_A];
    cal_b[`REMAP_DQ_B] = rise_ca_ff[`REMAP_CA_B];
    cal_b[`REMAP_DQ_B+1] = ca_s[`REMAP_CA_B];
  end

  assign cal_word = (mode_ff == ST_TRAIN_B) ? cal_b : cal_a;

  // DQ driver: calibration echo, leveling feedback, release on exit.
  // Training writes themselves are not echoed.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      dq_ff <= '0;
      dq_oe_ff <= '0;
    end
    else if (i_clk_en)
    begin
      if (nxt_mode == ST_NORMAL)
      begin
        dq_ff <= '0;
        dq_oe_ff <= '0;
      end
      else if (mode_ff == ST_LEVEL)
      begin
        if (dqs_rise)
        begin
          dq_ff <= {`DQ_WIDTH{ck_level}};
        end
      end
      else if (nxt_mode == ST_LEVEL)
      begin
        dq_ff <= '0;
        dq_oe_ff <= '1;
      end
      else if (cmd_done && (mode_ff == ST_TRAIN_A ||
               mode_ff == ST_TRAIN_B) && !hit_entry && !hit_remap)
      begin
        dq_ff <= cal_word;
        dq_oe_ff <= '1;
      end
    end
  end

  // Termination is a combinational switch: the pin is never sampled,
  // only qualified by configuration, mode and core status
  assign term_gate = (term_cfg_ff[`TERM_SEL_HI:`TERM_SEL_LO] != 2'h0) &&
                     !i_read_active && !i_self_refresh &&
                     !i_deep_power_down &&
                     (!i_power_down || term_cfg_ff[`TERM_PD_BIT]) &&
                     (mode_ff != ST_TRAIN_A) &&
                     (mode_ff != ST_TRAIN_B);
  assign o_odt_dqs = i_odt & term_gate;
  assign o_odt_dq = i_odt & term_gate & (mode_ff != ST_LEVEL);
  assign o_rtt_sel = term_cfg_ff[`TERM_SEL_HI:`TERM_SEL_LO];

  assign o_dq = dq_ff;
  assign o_dq_oe = dq_oe_ff;
  assign o_train_active = (mode_ff == ST_TRAIN_A) ||
                          (mode_ff == ST_TRAIN_B);
  assign o_level_active = (mode_ff == ST_LEVEL);
endmodule

/* File: dram_train_monitor.sv */
// Purpose: Concurrent checks on the training block's ports
// Assumes: One i_clock domain, synchronous active-high reset
// Notes: Bound to the design module below
`timescale 1ns/100ps
module dram_train_monitor
  import dram_train_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_odt,
  input wire logic i_dqs_t,
  input wire logic i_read_active,
  input wire logic i_self_refresh,
  input wire logic i_deep_power_down,
  input wire dq_t o_dq,
  input wire dq_t o_dq_oe,
  input wire logic o_odt_dq,
  input wire logic o_odt_dqs,
  input wire logic [1:0] o_rtt_sel,
  input wire logic o_train_active,
  input wire logic o_level_active
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  property p_odt_train;
    o_train_active |-> !o_odt_dq && !o_odt_dqs;
  endproperty
  a_odt_train: assert property (p_odt_train)
    else $error("termination on in training");
  property p_odt_block;
    i_read_active || i_self_refresh || i_deep_power_down
      |-> !o_odt_dq && !o_odt_dqs;
  endproperty
  a_odt_block: assert property (p_odt_block)
    else $error("termination on while blocked");
  property p_odt_pin;
    o_odt_dqs |-> i_odt && o_rtt_sel != 2'h0;
  endproperty
  a_odt_pin: assert property (p_odt_pin)
    else $error("termination on without pin or config");
  property p_odt_level;
    o_level_active |-> !o_odt_dq;
  endproperty
  a_odt_level: assert property (p_odt_level)
    else $error("data termination on in leveling");
  property p_oe_idle;
    !o_train_active && !o_level_active |-> o_dq_oe == '0;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pins driven outside training");
  property p_oe_whole;
    o_dq_oe != '0 |-> o_dq_oe == '1;
  endproperty
  a_oe_whole: assert property (p_oe_whole)
    else $error("partial data pin enable");
  property p_train_hi;
    o_train_active && o_dq_oe[0] |-> o_dq[31:16] == 16'h0;
  endproperty
  a_train_hi: assert property (p_train_hi)
    else $error("upper data pins not at fixed level");
  // Feedback may only move once a strobe rise has crossed the sync
  property p_level_fb;
    o_level_active && $past(o_level_active) && o_dq != $past(o_dq)
      |-> $past(i_dqs_t, 3);
  endproperty
  a_level_fb: assert property (p_level_fb)
    else $error("feedback changed without strobe");
endmodule
bind dram_ca_training_leveling_odt dram_train_monitor i_mon (
  .i_clock, .i_reset, .i_odt, .i_dqs_t, .i_read_active,
  .i_self_refresh, .i_deep_power_down, .o_dq, .o_dq_oe,
  .o_odt_dq, .o_odt_dqs, .o_rtt_sel, .o_train_active, .o_level_active);

/* File: ctrl_model.sv */
// Purpose: Memory controller model driving clock, command and strobe
// Assumes: Caller resumes just after an i_clock rising edge
// Notes: CK moves inside a frame or through set_ck, and stands still otherwise
`timescale 1ns/100ps
module ctrl_model
  import dram_train_pkg::*;
(
  input wire logic i_clock,
  output logic o_ck,
  output logic o_cs_n,
  output logic o_cke,
  output logic o_dqs_t,
  output ca_t o_ca
);
  initial
  begin
    o_ck = 1'b0;
    o_cs_n = 1'b1; // Idle cycles are no-operations
    o_cke = 1'b1; // Kept high so the remap write counts
    o_dqs_t = 1'b0; // Strobe parked low before pulsing
    o_ca = '0;
  end
  task wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Half CK period is four i_clock cycles, so CA is seen settled
  task cmd(input ca_t r, input ca_t f);
    o_ca = r; // Held a full CK cycle before the edge
    o_cs_n = 1'b0;
    wait_cyc(8);
    o_ck = 1'b1;
    wait_cyc(2);
    o_ca = f; // Equal to r for entry and exit
    o_cs_n = 1'b1;
    wait_cyc(2);
    o_ck = 1'b0;
    wait_cyc(2);
  endtask
  // Uneven waits give the shortened and stretched periods of a phase shift
  task set_ck(input logic v, input int n);
    o_ck = v;
    wait_cyc(n);
  endtask
  task set_cke(input logic v);
    o_cke = v; // Low while the clock phase moves and for the remap write that must be dropped
    wait_cyc(1);
  endtask
  // One strobe pair, swept on its own
  task strobe;
    o_dqs_t = 1'b1;
    wait_cyc(4);
    o_dqs_t = 1'b0;
    wait_cyc(4);
  endtask
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for training, leveling and termination
// Assumes: 25 MHz i_clock, 320 ns memory clock from the model
// Notes: Echo cases are table rows; termination and leveling by hand
`timescale 1ns/100ps
module tb_top import dram_train_pkg::*;;
  typedef struct {ca_t r; ca_t f; dq_t e;} row_s;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_odt = 1'b0;
  logic i_read_active = 1'b0;
  logic i_power_down = 1'b0;
  logic i_self_refresh = 1'b0;
  logic i_deep_power_down = 1'b0;
  logic clk_en = 1'b1;
  logic ck, cs_n, cke, dqs_t, odt_dq, odt_dqs, train_act, level_act;
  logic [1:0] rtt_sel;
  ca_t ca;
  dq_t dq, dq_oe;
  int err_total = 0;
  int comparisons = 0;
  row_s rows [7] = '{'{10'h3ff, 10'h000, 32'h5555},
    '{10'h000, 10'h3ff, 32'haaaa}, '{10'h001, 10'h100, 32'h8001},
    '{10'h010, 10'h000, 32'h0}, '{10'h210, 10'h000, 32'h101},
    '{10'h1ef, 10'h1ef, 32'h0}, '{10'h000, 10'h210, 32'h202}};
  ctrl_model i_ctrl (.i_clock, .o_ck(ck), .o_cs_n(cs_n), .o_cke(cke),
    .o_dqs_t(dqs_t), .o_ca(ca));
  dram_ca_training_leveling_odt i_dut (.i_clock, .i_reset,
    .i_clk_en(clk_en), .i_ck(ck), .i_cs_n(cs_n), .i_cke(cke), .i_ca(ca),
    .i_dqs_t(dqs_t), .i_odt, .i_read_active, .i_power_down,
    .i_self_refresh, .i_deep_power_down, .o_dq(dq), .o_dq_oe(dq_oe),
    .o_odt_dq(odt_dq), .o_odt_dqs(odt_dqs), .o_rtt_sel(rtt_sel),
    .o_train_active(train_act), .o_level_active(level_act));
  always #20 i_clock = ~i_clock;
  task chk(input string name, input dq_t exp, input dq_t got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task mrw(input logic [7:0] a, input logic [7:0] op);
    i_ctrl.cmd({a[5:0], 4'h0}, {op, a[7:6]});
    i_ctrl.wait_cyc(4);
  endtask
  task odt(input logic [3:0] st, input logic e);
    i_ctrl.wait_cyc(1);
    i_read_active = st[3];
    i_power_down = st[2];
    i_self_refresh = st[1];
    i_deep_power_down = st[0];
    #2;
    chk("odt_dq", {31'h0, e}, {31'h0, odt_dq});
    chk("odt_dqs", {31'h0, e}, {31'h0, odt_dqs});
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    i_ctrl.wait_cyc(5);
    chk("oe_rst", '0, dq_oe);
    chk("modes_rst", '0, {28'h0, train_act, level_act, rtt_sel});
    i_reset = 1'b0;
    $display("reset test done");
    mrw(8'h0b, 8'h05);
    chk("rtt", 32'h1, {30'h0, rtt_sel});
    i_odt = 1'b1;
    #2;
    chk("odt_pin", 32'h1, {31'h0, odt_dq});
    odt(4'h8, 1'b0);
    odt(4'h2, 1'b0);
    odt(4'h1, 1'b0);
    odt(4'h4, 1'b1);
    mrw(8'h0b, 8'h01);
    odt(4'h4, 1'b0);
    odt(4'h0, 1'b1);
    // A write while the block is frozen must leave no trace
    clk_en = 1'b0;
    mrw(8'h0b, 8'h06);
    clk_en = 1'b1;
    chk("freeze_rtt", 32'h1, {30'h0, rtt_sel});
    $display("termination test done");
    mrw(8'h29, 8'ha4);
    chk("train_on", 32'h1, {31'h0, train_act});
    chk("odt_train", 32'h0, {31'h0, odt_dqs});
    i_ctrl.set_cke(1'b0);
    i_ctrl.set_ck(1'b1, 3);
    i_ctrl.set_ck(1'b0, 7);
    i_ctrl.set_ck(1'b1, 5);
    i_ctrl.set_ck(1'b0, 4);
    chk("phase_oe", '0, dq_oe);
    chk("phase_train", 32'h1, {31'h0, train_act});
    // Remap with clock enable low is dropped; rows 0 to 3 expect session one
    mrw(8'h30, 8'hc0);
    chk("remap_cke", '0, dq_oe);
    i_ctrl.set_cke(1'b1);
    foreach (rows[i])
    begin
      if (i == 4)
        mrw(8'h30, 8'hc0);
      i_ctrl.cmd(rows[i].r, rows[i].f);
      i_ctrl.wait_cyc(4);
      chk("echo", rows[i].e, dq);
      chk("echo_oe", '1, dq_oe);
    end
    mrw(8'h2a, 8'ha8);
    chk("exit_oe", '0, dq_oe);
    chk("train_off", 32'h0, {31'h0, train_act});
    $display("training test done");
    mrw(8'h02, 8'h80);
    chk("level_on", 32'h1, {31'h0, level_act});
    chk("odt_lvl", 32'h2, {30'h0, odt_dqs, odt_dq});
    i_ctrl.set_ck(1'b1, 4);
    i_ctrl.strobe();
    chk("fb_one", '1, dq);
    i_ctrl.set_ck(1'b0, 4);
    i_ctrl.strobe();
    chk("fb_zero", '0, dq);
    mrw(8'h02, 8'h00);
    chk("level_off", '0, {31'h0, level_act});
    chk("level_oe", '0, dq_oe);
    $display("leveling test done");
    wrap_up();
  end
  initial
  begin
    #100000;
    err_total++;
    wrap_up();
  end
endmodule
